// ---- logic/ttf_defines.svh ----
// Constants of the turn-on timeout fault response block
`ifndef TTF_DEFINES_SVH
`define TTF_DEFINES_SVH

// ----------------------------------------
// Command code and register layout
// ----------------------------------------
`define TTF_CMD_ACTION 8'h63
`define TTF_ACTION_RST 8'h00
`define TTF_RESP_HI 7
`define TTF_RESP_LO 6
`define TTF_RETRY_HI 5
`define TTF_RETRY_LO 3
`define TTF_DELAY_HI 2
`define TTF_DELAY_LO 0

// ----------------------------------------
// Field codes
// ----------------------------------------
`define TTF_RESP_IGNORE 2'h0
`define TTF_RESP_KEEP 2'h1
`define TTF_RESP_DISABLE_RETRY 2'h2
`define TTF_RESP_LATCH_OFF 2'h3
`define TTF_RETRY_NONE 3'h0
`define TTF_RETRY_ENDLESS 3'h7

`endif

// ---- logic/ttf_pkg.sv ----
// Types of the turn-on timeout fault response block
package ttf_pkg;

	typedef enum logic [4:0] {
		TTF_RUN = 5'b00001,
		TTF_KEEP = 5'b00010,
		TTF_WAIT = 5'b00100,
		TTF_TRY = 5'b01000,
		TTF_HOLD = 5'b10000
	} ttf_state_e;

endpackage

// ---- logic/ttf_delay_timer.sv ----
// Delay timer counting 2^n fault time units
`timescale 1ns/1ps

module ttf_delay_timer #(
	parameter int UNIT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic [UNIT_W-1:0] unit_cycles,
	input wire logic [2:0] exp,
	// Result
	output logic done_q
);

	logic [UNIT_W-1:0] div_q;
	logic [7:0] units_q;
	logic [7:0] target_q;
	logic run_q;
	wire unit_tick;
	wire last_unit;

	// ----------------------------------------
	// Unit divider; a zero unit is read as one cycle
	// ----------------------------------------
	assign unit_tick = run_q && ((div_q + 1'b1) >= unit_cycles);
	assign last_unit = unit_tick && ((units_q + 8'h01) == target_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
			units_q <= 8'h00;
			target_q <= 8'h01;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				div_q <= '0;
				units_q <= 8'h00;
				target_q <= 8'h01 << exp; // RULE_12
				run_q <= 1'b1;
			end else if (run_q) begin
				div_q <= unit_tick ? '0 : div_q + 1'b1;
				if (unit_tick)
					units_q <= units_q + 8'h01;
				if (last_unit) begin
					run_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

endmodule

// ---- logic/ttf_fault_response.sv ----
// Turn-on timeout fault response controller
// ----------------------------------------
// What this block does
// RULE_01: Response 00 ignores the timeout fault; the output keeps running.
// RULE_02: Response 01 keeps running for the delay, then retries if fault remains.
// RULE_03: Response 10 disables the output at once, then follows the retry field.
// RULE_04: Response 11 disables the output until the latched fault is cleared.
// RULE_05: Status-bit clear or clear-faults command clears the latch and allows restart.
// RULE_06: Reset clears the latched fault.
// RULE_07: Commanding the output off then on, by pin or operation, clears.
// RULE_08: Retry code 000 makes no restart; output stays off until cleared.
// RULE_09: Retry codes 1 to 6 give that many attempts, then hold off.
// RULE_10: Attempt starts are spaced by the delay count times the time unit.
// RULE_11: Retry code 111 retries until commanded off or another fault shuts down.
// RULE_12: Delay field n selects 2^n time units, one to 128.
// RULE_13: The time unit comes from the output-voltage fault time-unit setting.
// RULE_14: Only some response encodings are honoured by the device; the code acts on all four codes 00 to 11.
// RULE_15: The configuration is one byte at command 0x63, byte read and write.
// RULE_16: A zero start-up limit disables the timeout fault entirely.
// RULE_17: A successful restart ends retrying and resets the attempt count.
// ----------------------------------------
`timescale 1ns/1ps
`include "ttf_defines.svh"

module ttf_fault_response import ttf_pkg::*; #(
	parameter int UNIT_W = 16,
	parameter int LIMIT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Byte command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid_q,
	output logic rsp_ack_q,
	output logic [7:0] rsp_rdata_q,
	// Fault clearing
	input wire logic clear_faults,
	input wire logic clear_status_bit,
	// On/off commands
	input wire logic ctrl_pin,
	input wire logic operation_on,
	// Start-up supervision
	input wire logic timeout_fault,
	input wire logic start_ok,
	input wire logic [LIMIT_W-1:0] turn_on_timeout_limit,
	input wire logic [UNIT_W-1:0] vout_fault_unit_cycles,
	input wire logic other_fault_shutdown,
	// Results
	output logic out_enable_q,
	output logic fault_latched_q,
	output logic attempt_start_q,
	output logic retrying_q,
	output logic [2:0] attempts_q
);

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	logic [7:0] turn_on_timeout_fault_action_q;
	wire cmd_hit;
	wire cfg_wr;
	wire [1:0] resp_code;
	wire [2:0] retry_code;
	wire [2:0] delay_code;

	assign cmd_hit = cmd_valid && (cmd_code == `TTF_CMD_ACTION); // RULE_15
	assign cfg_wr = cmd_hit && cmd_write;
	assign resp_code = turn_on_timeout_fault_action_q[`TTF_RESP_HI:`TTF_RESP_LO];
	assign retry_code = turn_on_timeout_fault_action_q[`TTF_RETRY_HI:`TTF_RETRY_LO];
	assign delay_code = turn_on_timeout_fault_action_q[`TTF_DELAY_HI:`TTF_DELAY_LO];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			turn_on_timeout_fault_action_q <= `TTF_ACTION_RST;
			rsp_valid_q <= 1'b0;
			rsp_ack_q <= 1'b0;
			rsp_rdata_q <= 8'h00;
		end else begin
			if (cfg_wr)
				turn_on_timeout_fault_action_q <= cmd_wdata; // RULE_15
			rsp_valid_q <= cmd_valid;
			rsp_ack_q <= cmd_hit;
			rsp_rdata_q <= (cmd_hit && !cmd_write) ? turn_on_timeout_fault_action_q : 8'h00;
		end
	end

	// ----------------------------------------
	// Control pin synchroniser
	// ----------------------------------------
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic pin_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			pin_s1_q <= ctrl_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q)
				pin_q <= pin_s2_q;
		end
	end

	// ----------------------------------------
	// Commanded on, fault event and clears
	// ----------------------------------------
	logic fault_seen_q;
	wire cmd_on;
	wire limit_on;
	wire fault_level;
	wire fault_event;
	wire clear_any;

	assign cmd_on = pin_q && operation_on;
	assign limit_on = (turn_on_timeout_limit != '0); // RULE_16
	assign fault_level = timeout_fault && limit_on; // RULE_16
	assign fault_event = fault_level && !fault_seen_q;
	// Being commanded off ends the latch; turning back on then restarts clean
	assign clear_any = clear_faults || clear_status_bit || !cmd_on; // RULE_05 RULE_07

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fault_seen_q <= 1'b0;
		else
			fault_seen_q <= fault_level;
	end

	// ----------------------------------------
	// Delay timer shared by keep-running and spacing
	// ----------------------------------------
	logic timer_start;
	logic timer_done;
	logic timer_expired_q;

	ttf_delay_timer #(
		.UNIT_W(UNIT_W)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.start(timer_start),
		.unit_cycles(vout_fault_unit_cycles), // RULE_13
		.exp(delay_code), // RULE_12
		.done_q(timer_done)
	);

	// ----------------------------------------
	// Response state machine
	// ----------------------------------------
	ttf_state_e state_q;
	ttf_state_e state_d;
	logic [2:0] attempts_d;
	logic latch_set;
	logic attempt_go;
	wire more_tries;
	wire spacing_over;

	assign more_tries = (retry_code == `TTF_RETRY_ENDLESS) || (attempts_q < retry_code); // RULE_09 RULE_11
	assign spacing_over = timer_done || timer_expired_q;

	always_comb begin
		state_d = state_q;
		attempts_d = attempts_q;
		timer_start = 1'b0;
		latch_set = 1'b0;
		attempt_go = 1'b0;
		case (state_q)
			TTF_RUN: begin
				if (fault_event) begin
					case (resp_code) // RULE_14
						`TTF_RESP_IGNORE: state_d = TTF_RUN; // RULE_01
						`TTF_RESP_KEEP: begin
							timer_start = 1'b1; // RULE_02
							state_d = TTF_KEEP;
						end
						`TTF_RESP_DISABLE_RETRY: begin
							latch_set = 1'b1; // RULE_03
							attempts_d = 3'h0;
							timer_start = 1'b1;
							state_d = (retry_code == `TTF_RETRY_NONE) ? TTF_HOLD : TTF_WAIT; // RULE_08
						end
						default: begin
							latch_set = 1'b1; // RULE_04
							state_d = TTF_HOLD;
						end
					endcase
				end
			end
			TTF_KEEP: begin
				if (timer_done) begin
					if (fault_level) begin
						latch_set = 1'b1; // RULE_02
						attempts_d = 3'h0;
						timer_start = 1'b1;
						state_d = (retry_code == `TTF_RETRY_NONE) ? TTF_HOLD : TTF_WAIT;
					end else begin
						state_d = TTF_RUN;
					end
				end
			end
			TTF_WAIT: begin
				if (spacing_over) begin
					if (more_tries) begin
						attempt_go = 1'b1;
						timer_start = 1'b1; // RULE_10
						attempts_d = (attempts_q == 3'h7) ? attempts_q : attempts_q + 3'h1;
						state_d = TTF_TRY;
					end else begin
						state_d = TTF_HOLD; // RULE_09
					end
				end
			end
			TTF_TRY: begin
				if (start_ok) begin
					attempts_d = 3'h0; // RULE_17
					state_d = TTF_RUN;
				end else if (fault_event) begin
					state_d = TTF_WAIT; // RULE_10
				end
			end
			TTF_HOLD: state_d = TTF_HOLD;
			default: state_d = TTF_RUN;
		endcase
		// A clear ends hold and retrying unless a new fault latches or another fault shuts down this cycle
		if (clear_any && !latch_set && state_q != TTF_KEEP) begin
			state_d = TTF_RUN; // RULE_05 RULE_07 RULE_11
			attempts_d = 3'h0;
		end
		if (other_fault_shutdown && (state_q == TTF_WAIT || state_q == TTF_TRY))
			state_d = TTF_HOLD; // RULE_11
	end

	// ----------------------------------------
	// State, latch and outputs
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= TTF_RUN;
			attempts_q <= 3'h0;
			timer_expired_q <= 1'b0;
			fault_latched_q <= 1'b0; // RULE_06
			out_enable_q <= 1'b0;
			attempt_start_q <= 1'b0;
			retrying_q <= 1'b0;
		end else begin
			state_q <= state_d;
			attempts_q <= attempts_d;
			timer_expired_q <= !timer_start && (timer_expired_q || timer_done);
			// Set wins over a clear in the same cycle
			fault_latched_q <= latch_set || (fault_latched_q && !clear_any); // RULE_05
			out_enable_q <= cmd_on && (state_d == TTF_RUN || state_d == TTF_KEEP || state_d == TTF_TRY);
			attempt_start_q <= attempt_go;
			retrying_q <= (state_d == TTF_WAIT) || (state_d == TTF_TRY);
		end
	end

endmodule

// ---- verification/ttf_checker.sv ----
// Property checker for the turn-on timeout fault response block
`timescale 1ns/1ps
module ttf_checker #(
	parameter int UNIT_W = 16,
	parameter int LIMIT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	input wire logic rsp_valid_q,
	input wire logic rsp_ack_q,
	input wire logic [7:0] rsp_rdata_q,
	// Fault side
	input wire logic clear_faults,
	input wire logic timeout_fault,
	input wire logic [LIMIT_W-1:0] turn_on_timeout_limit,
	input wire logic [UNIT_W-1:0] vout_fault_unit_cycles,
	input wire logic out_enable_q,
	input wire logic fault_latched_q,
	input wire logic attempt_start_q,
	input wire logic retrying_q,
	input wire logic [2:0] attempts_q
);
	logic [7:0] cfg_q;
	int gap_q;
	// Shadow config byte; gap counts cycles since the last attempt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= 8'h00;
			gap_q <= 1000;
		end else begin
			if (cmd_valid && cmd_write && cmd_code == 8'h63) begin
				cfg_q <= cmd_wdata;
			end
			gap_q <= attempt_start_q ? 1 : gap_q + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	answer_next_a: assert property (cmd_valid |=> rsp_valid_q) else $error("no answer");
	mapped_ack_a: assert property (cmd_valid && cmd_code == 8'h63 |=> rsp_ack_q) else $error("no ack");
	unmapped_refused_a: assert property (cmd_valid && cmd_code != 8'h63
		|=> !rsp_ack_q && rsp_rdata_q == 8'h00) else $error("unmapped code answered");
	disable_now_a: assert property ($rose(timeout_fault) && cfg_q[7] && turn_on_timeout_limit != 0
		&& out_enable_q && !retrying_q |=> fault_latched_q && !out_enable_q) else $error("late shutdown");
	ignore_fault_a: assert property (cfg_q[7:6] == 2'h0 && !fault_latched_q && !retrying_q
		|=> !fault_latched_q) else $error("ignored fault latched");
	zero_limit_a: assert property (turn_on_timeout_limit == 0 && !fault_latched_q && !retrying_q
		|=> !fault_latched_q) else $error("latched with zero limit");
	clear_drops_a: assert property (clear_faults && !timeout_fault |=> !fault_latched_q) else $error("clear lost");
	// The first reset edge only loads the flops; judge from the second one on
	reset_clears_a: assert property (disable iff (1'b0) rst ##1 rst |-> !fault_latched_q && !out_enable_q)
		else $error("latch kept in reset");
	no_retry_a: assert property (fault_latched_q && cfg_q[5:3] == 3'h0 |-> !attempt_start_q) else $error("retried");
	attempt_count_a: assert property (attempt_start_q && cfg_q[5:3] != 3'h7
		|-> attempts_q <= cfg_q[5:3]) else $error("too many attempts");
	attempt_gap_a: assert property (attempt_start_q
		|-> gap_q >= (32'h1 << cfg_q[2:0]) * vout_fault_unit_cycles) else $error("attempts too close");
endmodule
bind ttf_fault_response ttf_checker #(.UNIT_W(UNIT_W), .LIMIT_W(LIMIT_W)) i_ttf_checker (.clk(clk), .rst(rst),
	.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
	.rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q), .rsp_rdata_q(rsp_rdata_q), .clear_faults(clear_faults),
	.timeout_fault(timeout_fault), .turn_on_timeout_limit(turn_on_timeout_limit),
	.vout_fault_unit_cycles(vout_fault_unit_cycles), .out_enable_q(out_enable_q), .fault_latched_q(fault_latched_q),
	.attempt_start_q(attempt_start_q), .retrying_q(retrying_q), .attempts_q(attempts_q));

// ---- verification/ttf_host.sv ----
// Host model issuing byte commands to the fault response block
`timescale 1ns/1ps
module ttf_host (
	// Clock
	input wire logic clk,
	// Command side
	output logic cmd_valid = 1'b0,
	output logic cmd_write = 1'b0,
	output logic [7:0] cmd_code = 8'h00,
	output logic [7:0] cmd_wdata = 8'h00,
	// Answer side
	input wire logic rsp_valid_q,
	input wire logic rsp_ack_q,
	input wire logic [7:0] rsp_rdata_q
);
	// One byte per transfer; released lines flip so stale data never looks valid
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d, output logic a, output logic [7:0] r);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_code <= c;
		cmd_wdata <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
		cmd_wdata <= ~d;
		@(posedge clk);
		a = rsp_valid_q & rsp_ack_q;
		r = rsp_rdata_q;
	endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the turn-on timeout fault response block
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, cmd_write, rsp_valid_q, rsp_ack_q, out_enable_q, fault_latched_q, attempt_start_q, retrying_q;
	logic clear_faults = 1'b0, clear_status_bit = 1'b0, ctrl_pin = 1'b1, operation_on = 1'b1, other = 1'b0;
	logic timeout_fault = 1'b0, start_ok = 1'b0, fault_req = 1'b0, ok_mode = 1'b0, ack;
	logic [7:0] cmd_code, cmd_wdata, rsp_rdata_q, rd;
	logic [15:0] lim = 16'h0010;
	logic [2:0] attempts_q;
	int errors = 0;
	int tests_run = 0;
	int att_cnt = 0;
	always #2.5 clk = ~clk;
	ttf_host i_ttf_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q), .rsp_rdata_q(rsp_rdata_q));
	ttf_fault_response i_ttf_fault_response (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q),
		.rsp_rdata_q(rsp_rdata_q), .clear_faults(clear_faults), .clear_status_bit(clear_status_bit),
		.ctrl_pin(ctrl_pin), .operation_on(operation_on), .timeout_fault(timeout_fault), .start_ok(start_ok),
		.turn_on_timeout_limit(lim), .vout_fault_unit_cycles(16'h0002), .other_fault_shutdown(other),
		.out_enable_q(out_enable_q), .fault_latched_q(fault_latched_q), .attempt_start_q(attempt_start_q),
		.retrying_q(retrying_q), .attempts_q(attempts_q));
	// Start-up plant: each attempt drops the fault for a cycle, so a failed start re-raises it
	always @(posedge clk) begin
		timeout_fault <= fault_req & ~attempt_start_q;
		start_ok <= ok_mode & attempt_start_q;
		if (attempt_start_q === 1'b1) begin
			att_cnt <= att_cnt + 1;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] d);
		i_ttf_host.xfer(1'b1, 8'h63, d, ack, rd);
	endtask
	task automatic clr;
		fault_req <= 1'b0;
		tick(2);
		clear_faults <= 1'b1;
		tick(1);
		clear_faults <= 1'b0;
		tick(2);
	endtask
	task automatic s_regs;
		i_ttf_host.xfer(1'b0, 8'h63, 8'h00, ack, rd);
		check(rd, 8'h00);
		wr(8'ha5);
		i_ttf_host.xfer(1'b1, 8'h64, 8'h3c, ack, rd);
		check(ack, 1'b0);
		i_ttf_host.xfer(1'b0, 8'h63, 8'h00, ack, rd);
		check(rd, 8'ha5);
	endtask
	task automatic s_resp;
		for (int r = 0; r < 4; r++) begin
			wr({r[1:0], 6'h00});
			att_cnt <= 0;
			fault_req <= 1'b1;
			tick(3);
			check(fault_latched_q, r > 1);
			check(out_enable_q, r < 2);
			tick(12);
			check(fault_latched_q, r > 0);
			check(8'(att_cnt), 8'h00);
			fault_req <= 1'b0;
			tick(2);
			clear_status_bit <= 1'b1;
			tick(1);
			clear_status_bit <= 1'b0;
			tick(2);
			check({fault_latched_q, out_enable_q}, 8'h01);
		end
	endtask
	task automatic s_retry(input logic [2:0] n);
		wr({2'h2, n, 3'h3});
		att_cnt <= 0;
		fault_req <= 1'b1;
		tick(14);
		check(8'(att_cnt), 8'h00);
		tick(136);
		check(8'(att_cnt), n);
		check({retrying_q, out_enable_q, fault_latched_q}, 8'h01);
		clr;
	endtask
	task automatic s_latch_clear;
		for (int k = 0; k < 3; k++) begin
			wr(8'hc0);
			fault_req <= 1'b1;
			tick(4);
			fault_req <= 1'b0;
			check(fault_latched_q, 1'b1);
			ctrl_pin <= k != 0;
			operation_on <= k != 1;
			rst <= k == 2;
			tick(8);
			ctrl_pin <= 1'b1;
			operation_on <= 1'b1;
			rst <= 1'b0;
			tick(8);
			check({fault_latched_q, out_enable_q}, 8'h01);
		end
	endtask
	task automatic s_endless;
		wr(8'hb9);
		att_cnt <= 0;
		fault_req <= 1'b1;
		tick(100);
		check(8'(att_cnt > 8), 8'h01);
		other <= 1'b1;
		tick(3);
		check(retrying_q, 1'b0);
		other <= 1'b0;
		clr;
		wr(8'h91);
		fault_req <= 1'b1;
		tick(3);
		fault_req <= 1'b0;
		ok_mode <= 1'b1;
		tick(20);
		check({retrying_q, attempts_q, out_enable_q}, 8'h01);
		ok_mode <= 1'b0;
		clr;
		lim <= 16'h0000;
		wr(8'hc0);
		fault_req <= 1'b1;
		tick(5);
		check(fault_latched_q, 1'b0);
		fault_req <= 1'b0;
	endtask
	task automatic summarize;
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		tick(16);
		rst <= 1'b0;
		s_regs;
		s_resp;
		s_retry(3'h1);
		s_retry(3'h6);
		s_latch_clear;
		s_endless;
		summarize;
	end
endmodule
